// [core/sfspi_dev.sv]
`timescale 1ns/1ps

// ****************************************************************
// byte buffer
// ****************************************************************
module sfspi_fifo #(
	parameter int WIDTH = sfspi_pkg::FIFO_WIDTH,
	parameter int DEPTH = sfspi_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic rdy;
		logic vld;
	} sfspi_fifo_st_t;
	sfspi_fifo_st_t q, d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push, pop;

	assign push = in_valid && q.rdy;
	assign pop = out_ready && q.vld;
	assign in_ready = q.rdy;
	assign out_valid = q.vld;
	assign out_data = mem[q.rp];

	always_comb begin
		d = q;
		if (push) d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
		if (pop) d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
		d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		d.rdy = d.cnt != FULL_CNT;
		d.vld = d.cnt != '0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '{wp: '0, rp: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
		end else begin
			q <= d;
		end
	end

	// storage is not reset; valid gates every read of it
	always_ff @(posedge clock) begin
		if (push) mem[q.wp] <= in_data;
	end
endmodule // sfspi_fifo

// ****************************************************************
// flash side of the link
// ****************************************************************
module sfspi_dev #(
	parameter logic [7:0] STATUS_RD1_OP = 8'h05,
	parameter logic [7:0] STATUS_RD2_OP = 8'h35,
	parameter logic [7:0] SUSPEND_OP = 8'h75,
	parameter logic [7:0] STATUS_WR_OP = 8'h01
) (
	input wire logic clock,
	input wire logic rst,
	sfspi_if.dev link,
	input wire logic quad_enable_bit,
	input wire logic [1:0] status_protect_bits,
	input wire logic busy,
	input wire logic tx_on,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	output logic op_valid,
	output logic [7:0] op_code,
	output logic op_ignored,
	output logic sr_reject,
	output logic sr_locked,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic selected,
	output logic hold_active
);
	typedef struct packed {
		logic cs_m, cs_s, cs_p;
		logic ck_m, ck_s, ck_p;
		logic [3:0] ln_m, ln_s;
		sfspi_pkg::sfspi_ph_t ph;
		sfspi_pkg::sfspi_lw_t win, wout;
		logic quad_op;
		logic [7:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [7:0] tx_sh;
		logic [3:0] tx_cnt;
		logic tx_run;
		logic hold;
		logic [3:0] dout, doe_n;
		logic op_valid, op_ignored, sr_reject, sr_locked, rx_valid, selected;
		logic [7:0] op_code, rx_byte;
	} sfspi_dev_st_t;
	sfspi_dev_st_t q, d;
	logic rd_valid, pop, rise, fall, exempt;
	logic [7:0] rd_data, op, tx_byte;
	logic [3:0] cnt_n, bits_out;
	sfspi_pkg::sfspi_lw_t w_in;

	sfspi_fifo #(.WIDTH(8), .DEPTH(sfspi_pkg::FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(wr_valid),
		.in_data(wr_data),
		.in_ready(wr_ready),
		.out_valid(rd_valid),
		.out_data(rd_data),
		.out_ready(pop)
	);

	// edges found on the sampled clock whatever its idle level
	assign rise = q.ck_s && !q.ck_p;
	assign fall = !q.ck_s && q.ck_p;

	always_comb begin
		d = q;
		pop = 1'b0;
		op = '0;
		exempt = 1'b0;
		tx_byte = q.tx_sh;
		cnt_n = '0;
		bits_out = '0;
		w_in = (q.ph == sfspi_pkg::PH_OPC) ? sfspi_pkg::LW1 : q.win;
		d.cs_m = link.cs_n;
		d.cs_s = q.cs_m;
		d.cs_p = q.cs_s;
		d.ck_m = link.sclk;
		d.ck_s = q.ck_m;
		d.ck_p = q.ck_s;
		d.ln_m = link.lane;
		d.ln_s = q.ln_m;
		d.op_valid = 1'b0;
		d.op_ignored = 1'b0;
		d.sr_reject = 1'b0;
		d.rx_valid = 1'b0;
		d.selected = !q.cs_s;
		// protect pin counts only when it is not a data lane
		d.sr_locked = (status_protect_bits == sfspi_pkg::SP_HARDWARE) && !q.ln_s[2] &&
			!quad_enable_bit;
		if (q.cs_s) begin
			// only link state is cleared; the busy engine runs on untouched
			d.ph = sfspi_pkg::PH_IDLE;
			d.rx_cnt = '0;
			d.tx_cnt = '0;
			d.tx_run = 1'b0;
			d.hold = 1'b0;
			d.quad_op = 1'b0;
			d.win = sfspi_pkg::LW1;
			d.wout = sfspi_pkg::LW1;
		end else begin
			// a reset with select already low never counts as a fall
			if (q.cs_p) d.ph = sfspi_pkg::PH_OPC;
			// pause follows the pin only while the clock is low
			if (!q.ck_s) d.hold = !quad_enable_bit && !q.quad_op && !q.ln_s[3];
			if (!q.hold) begin
				if (rise && !q.tx_run && (q.ph == sfspi_pkg::PH_OPC ||
					q.ph == sfspi_pkg::PH_BODY)) begin
					d.rx_sh = sfspi_pkg::sfspi_shin(q.rx_sh, q.ln_s, w_in, q.ln_s[0]);
					cnt_n = q.rx_cnt + sfspi_pkg::sfspi_bits(w_in);
					d.rx_cnt = (cnt_n == sfspi_pkg::BYTE_BITS) ? '0 : cnt_n;
					if (cnt_n == sfspi_pkg::BYTE_BITS && q.ph == sfspi_pkg::PH_OPC) begin
						op = d.rx_sh;
						exempt = (op == STATUS_RD1_OP) || (op == STATUS_RD2_OP) ||
							(op == SUSPEND_OP);
						if ((busy && !exempt) || (sfspi_pkg::sfspi_is_quad(op) &&
							!quad_enable_bit)) begin
							d.ph = sfspi_pkg::PH_IGN;
							d.op_ignored = 1'b1;
						end else if (op == STATUS_WR_OP && q.sr_locked) begin
							d.ph = sfspi_pkg::PH_IGN;
							d.sr_reject = 1'b1;
						end else begin
							d.ph = sfspi_pkg::PH_BODY;
							d.op_valid = 1'b1;
							d.op_code = op;
							d.win = sfspi_pkg::sfspi_in_w(op);
							d.wout = sfspi_pkg::sfspi_out_w(op);
							d.quad_op = sfspi_pkg::sfspi_is_quad(op);
						end
					end else if (cnt_n == sfspi_pkg::BYTE_BITS) begin
						d.rx_valid = 1'b1;
						d.rx_byte = d.rx_sh;
					end
				end
				if (fall && q.ph == sfspi_pkg::PH_BODY && tx_on) begin
					if (q.tx_cnt == '0) begin
						// an empty buffer sends fill rather than stalling the host clock
						tx_byte = rd_valid ? rd_data : sfspi_pkg::TX_FILL;
						pop = rd_valid;
					end
					bits_out = sfspi_pkg::sfspi_wide(tx_byte, q.wout);
					d.dout = (q.wout == sfspi_pkg::LW1) ? {2'b00, bits_out[0], 1'b0} :
						bits_out;
					d.tx_sh = sfspi_pkg::sfspi_shl(tx_byte, q.wout);
					cnt_n = q.tx_cnt + sfspi_pkg::sfspi_bits(q.wout);
					d.tx_cnt = (cnt_n == sfspi_pkg::BYTE_BITS) ? '0 : cnt_n;
					d.tx_run = 1'b1;
				end
			end
		end
		if (!q.cs_s && d.tx_run && !d.hold) begin
			d.doe_n = (d.wout == sfspi_pkg::LW1) ? sfspi_pkg::DEV_SINGLE_OE_N :
				sfspi_pkg::sfspi_oe_n(d.wout);
		end else begin
			d.doe_n = sfspi_pkg::LANE_IDLE;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.doe_n <= sfspi_pkg::LANE_IDLE;
		end else begin
			q <= d;
		end
	end

	assign link.d_out = q.dout;
	assign link.d_oe_n = q.doe_n;
	assign op_valid = q.op_valid;
	assign op_code = q.op_code;
	assign op_ignored = q.op_ignored;
	assign sr_reject = q.sr_reject;
	assign sr_locked = q.sr_locked;
	assign rx_valid = q.rx_valid;
	assign rx_byte = q.rx_byte;
	assign selected = q.selected;
	assign hold_active = q.hold;
endmodule // sfspi_dev

// [pkg/sfspi_pkg.sv]
// ****************************************************************
// link constants and helpers
// ****************************************************************
package sfspi_pkg;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_WORD = 8'hE7;
	localparam logic [7:0] OP_QUAD_OCTAL = 8'hE3;
	localparam logic [1:0] SP_HARDWARE = 2'h1;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] TX_FILL = 8'hFF;
	localparam logic [3:0] LANE_IDLE = 4'hF;
	localparam logic [3:0] DEV_SINGLE_OE_N = 4'hD;
	localparam int CLK_PERIOD_NS = 8;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {LW1, LW2, LW4} sfspi_lw_t;
	typedef enum logic [1:0] {PH_IDLE, PH_OPC, PH_BODY, PH_IGN} sfspi_ph_t;
	typedef enum logic [2:0] {HP_IDLE, HP_LEAD, HP_RUN, HP_WAIT, HP_TAIL} sfspi_hph_t;
	typedef enum logic [1:0] {SG_OPC, SG_TX, SG_RX} sfspi_seg_t;

	function automatic logic [3:0] sfspi_bits(input sfspi_lw_t w);
		case (w)
			LW2: sfspi_bits = 4'h2;
			LW4: sfspi_bits = 4'h4;
			default: sfspi_bits = 4'h1;
		endcase
	endfunction

	function automatic logic sfspi_is_quad(input logic [7:0] op);
		sfspi_is_quad = (op == OP_QUAD_OUT) || (op == OP_QUAD_IO) ||
			(op == OP_QUAD_WORD) || (op == OP_QUAD_OCTAL);
	endfunction

	// width of address/data the host sends after the opcode
	function automatic sfspi_lw_t sfspi_in_w(input logic [7:0] op);
		if (op == OP_DUAL_IO) sfspi_in_w = LW2;
		else if (sfspi_is_quad(op) && op != OP_QUAD_OUT) sfspi_in_w = LW4;
		else sfspi_in_w = LW1;
	endfunction

	function automatic sfspi_lw_t sfspi_out_w(input logic [7:0] op);
		if (op == OP_DUAL_OUT || op == OP_DUAL_IO) sfspi_out_w = LW2;
		else if (sfspi_is_quad(op)) sfspi_out_w = LW4;
		else sfspi_out_w = LW1;
	endfunction

	// msb-first bits for one step; single-lane result sits on lane zero
	function automatic logic [3:0] sfspi_wide(input logic [7:0] sh, input sfspi_lw_t w);
		case (w)
			LW2: sfspi_wide = {2'b00, sh[7:6]};
			LW4: sfspi_wide = sh[7:4];
			default: sfspi_wide = {3'b000, sh[7]};
		endcase
	endfunction

	function automatic logic [7:0] sfspi_shl(input logic [7:0] sh, input sfspi_lw_t w);
		case (w)
			LW2: sfspi_shl = {sh[5:0], 2'b00};
			LW4: sfspi_shl = {sh[3:0], 4'h0};
			default: sfspi_shl = {sh[6:0], 1'b0};
		endcase
	endfunction

	function automatic logic [7:0] sfspi_shin(input logic [7:0] sh, input logic [3:0] l,
		input sfspi_lw_t w, input logic single_bit);
		case (w)
			LW2: sfspi_shin = {sh[5:0], l[1:0]};
			LW4: sfspi_shin = {sh[3:0], l};
			default: sfspi_shin = {sh[6:0], single_bit};
		endcase
	endfunction

	function automatic logic [3:0] sfspi_oe_n(input sfspi_lw_t w);
		case (w)
			LW2: sfspi_oe_n = 4'hC;
			LW4: sfspi_oe_n = 4'h0;
			default: sfspi_oe_n = 4'hE;
		endcase
	endfunction
endpackage

// [pkg/sfspi_if.sv]
`timescale 1ns/1ps
// ****************************************************************
// shared serial link
// ****************************************************************
interface sfspi_if;
	logic sclk;
	logic cs_n;
	logic [3:0] h_out;
	logic [3:0] h_oe_n;
	logic [3:0] d_out;
	logic [3:0] d_oe_n;
	logic [3:0] lane;

	// undriven lanes read high, as with a pull-up
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!d_oe_n[i]) lane[i] = d_out[i];
			else if (!h_oe_n[i]) lane[i] = h_out[i];
			else lane[i] = 1'b1;
		end
	end

	modport dev(input sclk, input cs_n, input lane, output d_out, output d_oe_n);
	modport host(output sclk, output cs_n, output h_out, output h_oe_n, input lane);
endinterface

// [core/sfspi_host.sv]
`timescale 1ns/1ps
// ****************************************************************
// bus master side of the link, clock mode zero
// ****************************************************************
module sfspi_host #(
	parameter logic [7:0] HALF_CYC = 8'(sfspi_pkg::LINK_HALF_CYC)
) (
	input wire logic clock,
	input wire logic rst,
	sfspi_if.host link,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire sfspi_pkg::sfspi_lw_t in_width,
	input wire sfspi_pkg::sfspi_lw_t out_width,
	input wire logic [7:0] tx_len,
	input wire logic [7:0] rx_len,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic busy,
	input wire logic wp_level,
	input wire logic hold_req
);
	typedef struct packed {
		sfspi_pkg::sfspi_hph_t ph;
		sfspi_pkg::sfspi_seg_t seg;
		sfspi_pkg::sfspi_lw_t win, wout;
		logic [7:0] div, sh, ntx, nrx, rxd;
		logic [3:0] cnt, ln_m, ln_s, hout, hoe_n;
		logic sclk, cs_n, txr, rxv, busy, hold;
	} sfspi_host_st_t;
	sfspi_host_st_t q, d;
	logic tick, quad;
	logic [3:0] cnt_n;
	sfspi_pkg::sfspi_lw_t w_cur;

	assign tick = (q.div == HALF_CYC - 8'h01) && !q.hold;

	always_comb begin
		d = q;
		cnt_n = '0;
		quad = 1'b0;
		w_cur = (q.seg == sfspi_pkg::SG_OPC) ? sfspi_pkg::LW1 :
			(q.seg == sfspi_pkg::SG_TX) ? q.win : q.wout;
		d.ln_m = link.lane;
		d.ln_s = q.ln_m;
		d.rxv = 1'b0;
		d.hold = hold_req;
		// a pause freezes the divider so no clock edge leaves during it
		if (q.ph != sfspi_pkg::HP_IDLE && q.ph != sfspi_pkg::HP_WAIT && !q.hold)
			d.div = tick ? '0 : q.div + 8'h01;
		case (q.ph)
			sfspi_pkg::HP_IDLE: begin
				d.cs_n = 1'b1;
				d.sclk = 1'b0;
				d.hoe_n = sfspi_pkg::LANE_IDLE;
				// select falls in the same cycle that the first opcode bit is driven
				if (start) begin
					d.cs_n = 1'b0;
					d.busy = 1'b1;
					d.ph = sfspi_pkg::HP_LEAD;
					d.seg = sfspi_pkg::SG_OPC;
					d.div = '0;
					d.cnt = '0;
					d.win = in_width;
					d.wout = out_width;
					d.ntx = tx_len;
					d.nrx = rx_len;
					d.hout = sfspi_pkg::sfspi_wide(opcode, sfspi_pkg::LW1);
					d.sh = sfspi_pkg::sfspi_shl(opcode, sfspi_pkg::LW1);
					d.hoe_n = sfspi_pkg::sfspi_oe_n(sfspi_pkg::LW1);
				end
			end
			sfspi_pkg::HP_LEAD: begin
				if (tick) d.ph = sfspi_pkg::HP_RUN;
			end
			sfspi_pkg::HP_RUN: begin
				if (tick && !q.sclk) begin
					d.sclk = 1'b1;
					cnt_n = q.cnt + sfspi_pkg::sfspi_bits(w_cur);
					d.cnt = cnt_n;
					if (q.seg == sfspi_pkg::SG_RX) begin
						d.sh = sfspi_pkg::sfspi_shin(q.sh, q.ln_s, q.wout, q.ln_s[1]);
						if (cnt_n == sfspi_pkg::BYTE_BITS) begin
							d.rxv = 1'b1;
							d.rxd = d.sh;
						end
					end
				end else if (tick) begin
					d.sclk = 1'b0;
					if (q.cnt == sfspi_pkg::BYTE_BITS) begin
						d.cnt = '0;
						if (q.seg == sfspi_pkg::SG_TX) d.ntx = q.ntx - 8'h01;
						if (q.seg == sfspi_pkg::SG_RX) d.nrx = q.nrx - 8'h01;
						if (d.ntx != '0) begin
							d.seg = sfspi_pkg::SG_TX;
							d.ph = sfspi_pkg::HP_WAIT;
							d.txr = 1'b1;
						end else if (d.nrx != '0) begin
							d.seg = sfspi_pkg::SG_RX;
							// release before the device turns the lanes round
							d.hoe_n = {2'b11, 1'b1, q.wout != sfspi_pkg::LW1};
							d.hout = '0;
						end else begin
							d.ph = sfspi_pkg::HP_TAIL;
						end
					end else if (q.seg != sfspi_pkg::SG_RX) begin
						d.hout = sfspi_pkg::sfspi_wide(q.sh, w_cur);
						d.sh = sfspi_pkg::sfspi_shl(q.sh, w_cur);
					end
				end
			end
			sfspi_pkg::HP_WAIT: begin
				// clock is held low while the source has no byte
				if (tx_valid && q.txr) begin
					d.txr = 1'b0;
					d.hout = sfspi_pkg::sfspi_wide(tx_data, q.win);
					d.sh = sfspi_pkg::sfspi_shl(tx_data, q.win);
					d.hoe_n = sfspi_pkg::sfspi_oe_n(q.win);
					d.ph = sfspi_pkg::HP_RUN;
					d.div = '0;
				end
			end
			sfspi_pkg::HP_TAIL: begin
				if (tick) begin
					d.cs_n = 1'b1;
					d.busy = 1'b0;
					d.ph = sfspi_pkg::HP_IDLE;
					// widths stay until the next start, so after a quad frame the
					// protect and pause pins stay released while the device lets go
					d.hoe_n = sfspi_pkg::LANE_IDLE;
				end
			end
			default: d.ph = sfspi_pkg::HP_IDLE;
		endcase
		quad = (d.win == sfspi_pkg::LW4) || (d.wout == sfspi_pkg::LW4);
		if (!quad) begin
			d.hout[3:2] = {!hold_req, wp_level};
			d.hoe_n[3:2] = 2'b00;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.cs_n <= 1'b1;
			q.hoe_n <= sfspi_pkg::LANE_IDLE;
		end else begin
			q <= d;
		end
	end

	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.h_out = q.hout;
	assign link.h_oe_n = q.hoe_n;
	assign tx_ready = q.txr;
	assign rx_valid = q.rxv;
	assign rx_data = q.rxd;
	assign busy = q.busy;
endmodule // sfspi_host

// [tb/sfspi_sva.sv]
`timescale 1ns/1ps
// ******
// link checker
// ******
module sfspi_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] h_out,
	input wire logic [3:0] h_oe_n,
	input wire logic [3:0] d_out,
	input wire logic [3:0] d_oe_n,
	input wire logic [3:0] lane
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_desel;
		cs_n [*6] |-> d_oe_n == 4'hF;
	endproperty
	a_desel: assert property (p_desel) else $error("lane driven while deselected");
	property p_rise_rel;
		$rose(cs_n) |-> ##[1:5] d_oe_n == 4'hF;
	endproperty
	a_rise_rel: assert property (p_rise_rel) else $error("lanes kept after select");
	property p_drv_low;
		$changed(d_out) && (d_oe_n != 4'hF) |-> !sclk;
	endproperty
	a_drv_low: assert property (p_drv_low) else $error("output moved on high clock");
	property p_lanes;
		d_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0};
	endproperty
	a_lanes: assert property (p_lanes) else $error("illegal lane set driven");
	property p_fight;
		(~d_oe_n & ~h_oe_n) == 4'h0;
	endproperty
	a_fight: assert property (p_fight) else $error("both ends drive one lane");
	property p_cs_edge;
		$fell(cs_n) || $rose(cs_n) |-> !sclk;
	endproperty
	a_cs_edge: assert property (p_cs_edge) else $error("clock high at select edge");
	property p_still;
		cs_n [*2] |-> $stable(sclk);
	endproperty
	a_still: assert property (p_still) else $error("clock runs while idle");
	// pause pin held low with clock low must release the output lanes
	property p_hold;
		(!cs_n && !h_oe_n[3] && !lane[3] && !sclk) [*8] |-> d_oe_n[1:0] == 2'b11;
	endproperty
	a_hold: assert property (p_hold) else $error("output driven in pause");
endmodule // sfspi_sva

// [tb/sfspi_tb_top.sv]
`timescale 1ns/1ps
// ******
// bench for both link ends
// ******
module sfspi_tb_top;
	logic clock, cpol = 1'b0, rst = 1'b1, start = 1'b0, tx_valid = 1'b0, tx_on = 1'b0;
	logic wr_valid = 1'b0, busy = 1'b0, quad_en = 1'b0, prot_lvl = 1'b1, hold_req = 1'b0;
	logic tx_ready, h_rxv, h_busy, wr_ready, op_valid, op_ign, sr_rej, d_rxv, hold_act, op_v2;
	logic [7:0] opcode = 8'h00, tx_len = 8'h00, rx_len = 8'h00, tx_data = 8'h00, wr_data = 8'h00;
	logic sel_a, sr_lk;
	logic [7:0] h_rxd, op_code, rx_byte, op_c2, op, last_op;
	logic [1:0] sp_bits = 2'h0;
	logic [31:0] seed = 32'h000008BD;
	sfspi_pkg::sfspi_lw_t in_w = sfspi_pkg::LW1, out_w = sfspi_pkg::LW1;
	logic [7:0] tq[$], dq[$], hq[$], fq[$];
	logic [7:0] ops[8] = '{8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'hE3, 8'h0B, 8'h00};
	logic [7:0] bops[4] = '{8'h05, 8'h35, 8'h75, 8'h0B};
	// protect bits, pin, quad enable, expected refusal
	logic [4:0] srow[4] = '{5'h09, 5'h0C, 5'h00, 5'h0A};
	int n_mismatch = 0, checks = 0, n_ev = 0, n_ign = 0, n_rej = 0, n_op2 = 0, k = 0;

	sfspi_if link_a();
	sfspi_if link_b();

	sfspi_host u_sfspi_host (.clock(clock), .rst(rst), .link(link_a.host), .start(start),
		.opcode(opcode), .in_width(in_w), .out_width(out_w), .tx_len(tx_len), .rx_len(rx_len),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(h_rxv),
		.rx_data(h_rxd), .busy(h_busy), .wp_level(prot_lvl), .hold_req(hold_req));
	sfspi_dev u_sfspi_dev (.clock(clock), .rst(rst), .link(link_a.dev), .quad_enable_bit(quad_en),
		.status_protect_bits(sp_bits), .busy(busy), .tx_on(tx_on), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_ready(wr_ready), .op_valid(op_valid), .op_code(op_code),
		.op_ignored(op_ign), .sr_reject(sr_rej), .sr_locked(sr_lk), .rx_valid(d_rxv),
		.rx_byte(rx_byte), .selected(sel_a), .hold_active(hold_act));
	// second device faces a bit-banged host that breaks the select rules
	sfspi_dev u_sfspi_dev_b (.clock(clock), .rst(rst), .link(link_b.dev),
		.quad_enable_bit(quad_en), .status_protect_bits(sp_bits), .busy(busy), .tx_on(1'b0),
		.wr_valid(1'b0), .wr_data(wr_data), .wr_ready(), .op_valid(op_v2), .op_code(op_c2),
		.op_ignored(), .sr_reject(), .sr_locked(), .rx_valid(), .rx_byte(), .selected(),
		.hold_active());
	sfspi_sva u_sfspi_sva (.clock(clock), .rst(rst), .sclk(link_a.sclk), .cs_n(link_a.cs_n),
		.h_out(link_a.h_out), .h_oe_n(link_a.h_oe_n), .d_out(link_a.d_out),
		.d_oe_n(link_a.d_oe_n), .lane(link_a.lane));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	always @(posedge clock) begin
		if (op_valid) last_op = op_code;
		if (op_valid || op_ign || d_rxv) n_ev++;
		if (op_ign) n_ign++;
		if (sr_rej) n_rej++;
		if (d_rxv) dq.push_back(rx_byte);
		if (h_rxv) hq.push_back(h_rxd);
		if (op_v2) n_op2++;
	end

	// ******
	// helpers
	// ******
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	function automatic logic isq(input logic [7:0] c);
		return c inside {8'h6B, 8'hEB, 8'hE7, 8'hE3};
	endfunction

	// lane width per phase: o=0 address/data in, o=1 read data out
	function automatic sfspi_pkg::sfspi_lw_t lw_of(input logic [7:0] c, input logic o);
		if (isq(c) && (o || c != 8'h6B)) return sfspi_pkg::LW4;
		if ((c == 8'h3B && o) || c == 8'hBB) return sfspi_pkg::LW2;
		return sfspi_pkg::LW1;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// push until n bytes taken or the buffer refuses
	task automatic fill(input int n);
		k = 0;
		while (k < n) begin
			wr_valid <= 1'b1;
			wr_data <= rnd8();
			@(posedge clock);
			if (wr_ready !== 1'b1) break;
			fq.push_back(wr_data);
			k++;
		end
		wr_valid <= 1'b0;
		@(posedge clock);
	endtask

	task automatic run(input logic [7:0] c, input int ntx, input int nrx, input logic ign);
		int g;
		logic [7:0] b;
		if (!ign) fill(nrx);
		tq.delete();
		dq.delete();
		hq.delete();
		n_ev = 0;
		n_ign = 0;
		n_rej = 0;
		last_op = 8'h00;
		opcode <= c;
		in_w <= lw_of(c, 1'b0);
		out_w <= lw_of(c, 1'b1);
		tx_len <= 8'(ntx);
		rx_len <= 8'(nrx);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		for (int i = 0; i < ntx; i++) begin
			b = rnd8();
			tq.push_back(b);
			tx_data <= b;
			tx_valid <= 1'b1;
			g = 0;
			do begin
				@(posedge clock);
				g++;
			end while (tx_ready !== 1'b1 && g < 2000);
			if (g >= 2000) n_mismatch++;
		end
		tx_valid <= 1'b0;
		g = 0;
		// read data may only be offered once the last inbound byte has landed
		while (nrx > 0 && n_ev < (ign ? 1 : ntx + 1) && g < 2000) begin
			@(posedge clock);
			g++;
		end
		if (g >= 2000) n_mismatch++;
		tx_on <= (nrx > 0);
		repeat (3) @(posedge clock);
		g = 0;
		while (h_busy !== 1'b0 && g < 9000) begin
			@(posedge clock);
			g++;
		end
		if (g >= 9000) n_mismatch++;
		tx_on <= 1'b0;
		@(posedge clock);
		chk(n_ign, ign);
		if (!ign && c != 8'h01) chk(last_op, c);
		for (int i = 0; i < ntx; i++) if (!ign) chk(dq[i], tq[i]);
		for (int i = 0; i < nrx; i++) chk(hq[i], (!ign && i < fq.size()) ? fq[i] : 8'hFF);
		repeat (nrx) if (fq.size() > 0) void'(fq.pop_front());
	endtask

	task automatic csb(input logic v);
		link_b.cs_n <= v;
		repeat (10) @(posedge clock);
	endtask

	task automatic bb(input logic [7:0] v, input int nb);
		for (int i = 0; i < nb; i++) begin
			link_b.h_out[0] <= v[7-i];
			link_b.sclk <= 1'b0;
			repeat (10) @(posedge clock);
			link_b.sclk <= 1'b1;
			repeat (10) @(posedge clock);
		end
		link_b.sclk <= cpol;
		repeat (10) @(posedge clock);
	endtask

	// ******
	// main sequence
	// ******
	initial begin
		link_b.cs_n = 1'b0;
		link_b.sclk = 1'b0;
		link_b.h_out = 4'hF;
		link_b.h_oe_n = 4'hE;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		chk(link_a.d_oe_n, 4'hF);
		bb(8'h9F, 8);
		chk(n_op2, 0);
		csb(1'b1);
		csb(1'b0);
		bb(8'hC3, 5);
		csb(1'b1);
		cpol = 1'b1;
		link_b.sclk <= 1'b1;
		csb(1'b0);
		bb(8'hA5, 8);
		csb(1'b1);
		chk(n_op2, 1);
		chk(op_c2, 8'hA5);
		for (int q = 0; q < 2; q++) begin
			quad_en <= q[0];
			for (int i = 0; i < 8; i++) begin
				op = (i == 7) ? rnd8() : ops[i];
				run(op, 2, 2, isq(op) && q == 0);
			end
		end
		quad_en <= 1'b0;
		busy <= 1'b1;
		foreach (bops[i]) run(bops[i], 0, 1, bops[i] == 8'h0B);
		busy <= 1'b0;
		foreach (srow[i]) begin
			{sp_bits, prot_lvl, quad_en} <= srow[i][4:1];
			run(8'h01, 0, 0, 1'b0);
			chk(n_rej, srow[i][0]);
			chk(sr_lk, srow[i][0]);
		end
		quad_en <= 1'b0;
		prot_lvl <= 1'b1;
		fill(20);
		chk(k, 16);
		fork
			run(8'h03, 0, 17, 1'b0);
			begin
				wait (hq.size() >= 3);
				@(negedge link_a.sclk);
				@(posedge clock);
				hold_req <= 1'b1;
				repeat (60) @(posedge clock);
				chk(hold_act, 1'b1);
				chk(link_a.d_oe_n, 4'hF);
				chk(sel_a, 1'b1);
				hold_req <= 1'b0;
			end
		join
		close_out();
	end

	// generous bound: the whole sequence needs roughly a sixth of this
	initial begin
		repeat (90000) @(posedge clock);
		n_mismatch++;
		close_out();
	end
endmodule // sfspi_tb_top
